/* File: verilog/mst_scan_seq.sv */
// Behaviour
// (RQ1) Each voltage conversion lasts 10.6 us and each temperature conversion 46 us.
// (RQ2) A differential pair takes one conversion slot; its odd input is never converted alone.
// (RQ3) In reference mode 00 a 20 us reference power-up precedes every temperature conversion.
// (RQ4) In reference mode 01 a 40 us power-up follows each sample wait only if it exceeds 80 us.
// (RQ5) In reference mode 10 no reference power-up is ever inserted.
// (RQ6) A scan lasts power-up plus voltage and temperature conversion times plus the sample wait.
// (RQ7) The sample wait is chosen by the three-bit field in bits 5 to 7 of the setup register.
// (RQ8) All conversion timing counts the internal clock and nothing from the host; the code counts SYS_CLK only while CLK_EN is high.
// (RQ9) The reference shuts down automatically in mode 00, and in mode 01 after a long wait.
// (RQ10) A differential temperature pair uses the even input as anode and the odd as cathode.
// (RQ11) The host marks a pair differential temperature and enables only its even channel.
// (RQ12) The host marks a single-ended temperature input and enables its channel bit.
// (RQ13) Each temperature result is kept as a 12-bit two's complement code of 0.125 C steps.
// (RQ14) An active scan converts each enabled slot in turn, waits, then restarts from the first.
`timescale 1ns/1ns
module mst_scan_seq
  import mst_pkg::*;
#(
  parameter int TCONV_CYCLES = TCONV_CYC,
  parameter int REF01_CYCLES = REF01_CYC,
  parameter int LONG_WAIT_CYCLES = LONG_WAIT_CYC,
  parameter int WAIT_STEP_CYCLES = WAIT_STEP_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [11:0] CONV_DATA,
  output logic CONV_START,
  output mst_conv_cmd_t CONV_CMD,
  output logic CONV_BUSY,
  output logic REF_SHDN
);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_temp(input logic [3:0] c, input mst_cfg_t g);
    if (c == CH_INT_TEMP) return 1'b1;
    if (c == CH_SUPPLY) return 1'b0;
    return g.temp_sel[c[2:0]];
  endfunction

  function automatic logic slot_ok(input logic [3:0] c, input mst_cfg_t g);
    logic odd_of_pair;
    odd_of_pair = (c < CH_INT_TEMP) && c[0] && g.diff_sel[c[2:1]]; // RQ2
    return (32'(c) < NUM_CH) && g.chan_en[c] && !odd_of_pair;
  endfunction

  // First usable slot at or above 'from'; bit 4 says one was found
  function automatic logic [4:0] find_slot(input logic [3:0] from, input mst_cfg_t g);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (4'(i) >= from && slot_ok(4'(i), g)) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  function automatic logic [31:0] wait_cycles(input logic [2:0] sel);
    return 32'(sel) * 32'(WAIT_STEP_CYCLES);
  endfunction

  function automatic logic [31:0] conv_cycles(input logic [3:0] c, input mst_cfg_t g);
    return is_temp(c, g) ? 32'(TCONV_CYCLES) : 32'(VCONV_CYC);
  endfunction

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  mst_cfg_t cfg_r, cfg_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic err_r, err_nxt;
  logic res_rd_r, res_rd_nxt;
  logic setup_ph, wr_acc, res_hit;
  logic [11:0] mem_rdata;
  mst_state_t state_r, state_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] per_cnt_r, per_cnt_nxt, period_r, period_nxt;
  logic start_r, start_nxt, shdn_r, shdn_nxt, wr_res;
  logic long_wait;
  logic [4:0] next_slot;

  assign setup_ph = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE && CLK_EN;
  assign res_hit = (PADDR[7:6] == ADDR_RES_PAGE) && (32'(PADDR[5:2]) < NUM_CH);
  assign long_wait = wait_cycles(cfg_r.wait_sel) > 32'(LONG_WAIT_CYCLES);
  assign next_slot = find_slot(4'(chan_r + 4'h1), cfg_r);

  // Writes land at the access edge; reads are captured in setup
  always_comb begin
    cfg_nxt = cfg_r;
    prdata_nxt = prdata_r;
    err_nxt = err_r;
    res_rd_nxt = res_rd_r;
    if (wr_acc && PADDR == ADDR_SETUP) begin
      cfg_nxt.scan_en = PWDATA[SETUP_SCAN_BIT];
      cfg_nxt.ref_mode = PWDATA[SETUP_REF_LSB +: 2];
      cfg_nxt.wait_sel = PWDATA[SETUP_WAIT_LSB +: 3]; // RQ7
    end
    if (wr_acc && PADDR == ADDR_CHAN_EN) begin
      cfg_nxt.chan_en = PWDATA[9:0];
    end
    if (wr_acc && PADDR == ADDR_INPUT_CFG) begin
      cfg_nxt.temp_sel = PWDATA[CFG_TEMP_LSB +: 8];
      cfg_nxt.diff_sel = PWDATA[CFG_DIFF_LSB +: 4];
    end
    if (setup_ph) begin
      res_rd_nxt = res_hit;
      err_nxt = 1'b0;
      unique case (PADDR)
        ADDR_SETUP: prdata_nxt = {24'h0, cfg_r.wait_sel, 2'h0, cfg_r.ref_mode,
                                  cfg_r.scan_en};
        ADDR_CHAN_EN: prdata_nxt = {22'h0, cfg_r.chan_en};
        ADDR_INPUT_CFG: prdata_nxt = {20'h0, cfg_r.diff_sel, cfg_r.temp_sel};
        ADDR_STATUS: prdata_nxt = {24'h0, CONV_BUSY, shdn_r, chan_r, state_r};
        ADDR_SCAN_PERIOD: prdata_nxt = period_r;
        default: begin
          prdata_nxt = 32'h0;
          err_nxt = !res_hit;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= '{scan_en: SETUP_RST[SETUP_SCAN_BIT],
                 ref_mode: SETUP_RST[SETUP_REF_LSB +: 2],
                 wait_sel: SETUP_RST[SETUP_WAIT_LSB +: 3],
                 chan_en: CHAN_EN_RST,
                 temp_sel: INPUT_CFG_RST[CFG_TEMP_LSB +: 8],
                 diff_sel: INPUT_CFG_RST[CFG_DIFF_LSB +: 4]};
      prdata_r <= 32'h0;
      err_r <= 1'b0;
      res_rd_r <= 1'b0;
    end else if (CLK_EN) begin
      cfg_r <= cfg_nxt;
      prdata_r <= prdata_nxt;
      err_r <= err_nxt;
      res_rd_r <= res_rd_nxt;
    end
  end

  // Zero wait states; a frozen clock enable stalls the access
  assign PREADY = CLK_EN;
  assign PSLVERR = PSEL && PENABLE && err_r;
  assign PRDATA = res_rd_r ? {20'h0, mem_rdata} : prdata_r;

  // ----------------------------------------------------------------
  // Result store
  // ----------------------------------------------------------------
  // Codes are kept untouched; temperature arrives as signed 0.125 C steps
  mst_result_mem #(.DW(RES_W), .DEPTH(NUM_CH), .AW(4)) u_mem (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .ce(CLK_EN),
    .we(wr_res), // RQ13
    .waddr(chan_r),
    .wdata(CONV_DATA),
    .re(setup_ph && !PWRITE && res_hit),
    .raddr(PADDR[5:2]),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  // Every count runs on SYS_CLK gated by CLK_EN, so a frozen clock enable stretches a slot
  always_comb begin
    logic [4:0] slot;
    logic go, start_scan;
    slot = 5'h00;
    go = 1'b0;
    start_scan = 1'b0;
    state_nxt = state_r;
    chan_nxt = chan_r;
    cnt_nxt = cnt_r;
    start_nxt = 1'b0;
    wr_res = 1'b0;
    per_cnt_nxt = per_cnt_r + 32'h1;
    period_nxt = period_r;
    unique case (state_r)
      ST_IDLE: start_scan = cfg_r.scan_en;
      ST_REF: begin
        cnt_nxt = cnt_r - 32'h1;
        if (cnt_r <= 32'h1) begin
          if (slot_ok(chan_r, cfg_r)) begin
            state_nxt = ST_CONV;
            cnt_nxt = conv_cycles(chan_r, cfg_r); // RQ1
            start_nxt = 1'b1;
          end else begin
            state_nxt = ST_WAIT;
            cnt_nxt = wait_cycles(cfg_r.wait_sel);
          end
        end
      end
      ST_CONV: begin
        cnt_nxt = cnt_r - 32'h1; // RQ8
        if (cnt_r <= 32'h1) begin
          wr_res = 1'b1;
          slot = next_slot; // RQ14
          go = slot[4];
          if (!go) begin
            state_nxt = ST_WAIT;
            cnt_nxt = wait_cycles(cfg_r.wait_sel); // RQ7
          end
        end
      end
      ST_WAIT: begin
        cnt_nxt = cnt_r - 32'h1;
        if (cnt_r <= 32'h1) begin
          start_scan = cfg_r.scan_en;
          if (!cfg_r.scan_en) state_nxt = ST_IDLE;
        end
      end
    endcase
    // New scan: time since the last start is the measured period
    if (start_scan) begin
      period_nxt = per_cnt_r; // RQ6
      per_cnt_nxt = 32'h1;
      slot = find_slot(4'h0, cfg_r);
      if (cfg_r.ref_mode == REF_MODE_01 && long_wait) begin
        state_nxt = ST_REF; // RQ4
        chan_nxt = slot[3:0];
        cnt_nxt = 32'(REF01_CYCLES);
      end else if (slot[4]) begin
        go = 1'b1;
      end else begin
        state_nxt = ST_WAIT;
        cnt_nxt = wait_cycles(cfg_r.wait_sel);
      end
    end
    // Launch a slot; mode 00 powers the reference before temperature only
    if (go) begin
      chan_nxt = slot[3:0];
      if (cfg_r.ref_mode == REF_MODE_00 && is_temp(slot[3:0], cfg_r)) begin
        state_nxt = ST_REF; // RQ3
        cnt_nxt = 32'(REF00_CYC);
      end else begin
        state_nxt = ST_CONV; // RQ5
        cnt_nxt = conv_cycles(slot[3:0], cfg_r);
        start_nxt = 1'b1;
      end
    end
    // Reference off unless needed; modes 10 and 11 keep it on
    unique case (cfg_r.ref_mode)
      REF_MODE_00: shdn_nxt = !(state_nxt == ST_REF ||
                                (state_nxt == ST_CONV && is_temp(chan_nxt, cfg_r))); // RQ9
      REF_MODE_01: shdn_nxt = long_wait && (state_nxt == ST_WAIT || state_nxt == ST_IDLE);
      default: shdn_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      chan_r <= 4'h0;
      cnt_r <= 32'h0;
      per_cnt_r <= 32'h0;
      period_r <= 32'h0;
      start_r <= 1'b0;
      shdn_r <= 1'b1;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      cnt_r <= cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      period_r <= period_nxt;
      start_r <= start_nxt;
      shdn_r <= shdn_nxt;
    end
  end

  // Differential pair: the even channel number names the anode input
  assign CONV_CMD = '{chan: chan_r, temp: is_temp(chan_r, cfg_r),
                      diff: (chan_r < CH_INT_TEMP) && cfg_r.diff_sel[chan_r[2:1]]}; // RQ10
  assign CONV_START = start_r;
  assign CONV_BUSY = (state_r == ST_CONV);
  assign REF_SHDN = shdn_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] conv_len_r;
  // Restarts with every slot, so back-to-back conversions are measured apart
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) conv_len_r <= 32'h0;
    else if (CLK_EN) conv_len_r <= start_nxt ? 32'h0 : conv_len_r + 32'h1;
  end

  sequence seq_conv_end;
    CLK_EN && state_r == ST_CONV && cnt_r == 32'h1;
  endsequence
  sequence seq_enter_conv;
    CLK_EN && state_r != ST_CONV ##1 state_r == ST_CONV;
  endsequence

  AST_CONV_LEN: assert property (seq_conv_end |-> // RQ1
      conv_len_r + 32'h1 == conv_cycles(chan_r, cfg_r))
    else $error("conversion slot length wrong");
  AST_REF00_BEFORE_TEMP: assert property (seq_enter_conv ##0 // RQ3
      (cfg_r.ref_mode == REF_MODE_00 && CONV_CMD.temp) |-> $past(state_r) == ST_REF)
    else $error("temperature conversion without reference power-up");
  AST_REF01_LONG: assert property (state_r == ST_REF && cfg_r.ref_mode == REF_MODE_01 // RQ4
      |-> long_wait)
    else $error("mode 01 power-up after short wait");
  AST_NO_REF_MODE10: assert property (cfg_r.ref_mode[1] |-> ##1 // RQ5
      (state_r != ST_REF || $past(state_r) == ST_REF))
    else $error("reference power-up entered in mode 10");
  AST_DIFF_ONE_SLOT: assert property (state_r == ST_CONV && chan_r < CH_INT_TEMP // RQ2
      && cfg_r.diff_sel[chan_r[2:1]] |-> !chan_r[0])
    else $error("odd input of a differential pair converted");
  AST_WAIT_LOAD: assert property (seq_conv_end ##0 !next_slot[4] // RQ7
      |=> state_r == ST_WAIT && cnt_r == wait_cycles($past(cfg_r.wait_sel)))
    else $error("sample wait not loaded from setup field");
  AST_SHDN_MODE: assert property ((cfg_r.ref_mode[1] && $past(cfg_r.ref_mode[1]) // RQ9
      |-> !REF_SHDN) and (state_r == ST_WAIT && cfg_r.ref_mode == REF_MODE_00
      && $stable(cfg_r) |-> REF_SHDN))
    else $error("automatic shutdown wrong for reference mode");
  AST_SCAN_ORDER: assert property (seq_conv_end ##0 next_slot[4] // RQ14
      |=> chan_r > $past(chan_r))
    else $error("scan did not advance to a later slot");
  AST_RESULT_WRITE: assert property (wr_res |-> state_r == ST_CONV // RQ13
      && conv_len_r + 32'h1 == conv_cycles(chan_r, cfg_r))
    else $error("result written outside conversion end");
  AST_START_PULSE: assert property (CLK_EN && CONV_START |=> !CONV_START || !CLK_EN) // RQ8
    else $error("conversion start longer than one cycle");

endmodule // mst_scan_seq

/* File: verilog/mst_pkg.sv */
package mst_pkg;

  // ----------------------------------------------------------------
  // Timing, in the units given and in 125 MHz clock cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int VCONV_NS = 10600;
  localparam int TCONV_NS = 46000;
  localparam int REF00_NS = 20000;
  localparam int REF01_NS = 40000;
  localparam int LONG_WAIT_NS = 80000;
  localparam int WAIT_STEP_NS = 40000;
  // Least times round up to whole cycles
  localparam int VCONV_CYC = (VCONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TCONV_CYC = (TCONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF00_CYC = (REF00_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF01_CYC = (REF01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Threshold compared exactly, so it is not rounded
  localparam int LONG_WAIT_CYC = LONG_WAIT_NS / CLK_PERIOD_NS;
  localparam int WAIT_STEP_CYC = (WAIT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Channels: 0..7 external inputs, 8 internal temperature, 9 supply
  // ----------------------------------------------------------------
  localparam int NUM_CH = 10;
  localparam logic [3:0] CH_INT_TEMP = 4'h8;
  localparam logic [3:0] CH_SUPPLY = 4'h9;
  localparam int RES_W = 12;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SETUP = 8'h00;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h04;
  localparam logic [7:0] ADDR_INPUT_CFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_SCAN_PERIOD = 8'h10;
  localparam logic [1:0] ADDR_RES_PAGE = 2'h1;
  localparam int SETUP_SCAN_BIT = 0;
  localparam int SETUP_REF_LSB = 1;
  localparam int SETUP_WAIT_LSB = 5;
  localparam int CFG_TEMP_LSB = 0;
  localparam int CFG_DIFF_LSB = 8;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [9:0] CHAN_EN_RST = 10'h3ff;
  localparam logic [11:0] INPUT_CFG_RST = 12'h000;

  // Reference modes
  localparam logic [1:0] REF_MODE_00 = 2'h0;
  localparam logic [1:0] REF_MODE_01 = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REF = 2'b01,
    ST_CONV = 2'b10,
    ST_WAIT = 2'b11
  } mst_state_t;

  typedef struct packed {
    logic scan_en;
    logic [1:0] ref_mode;
    logic [2:0] wait_sel;
    logic [9:0] chan_en;
    logic [7:0] temp_sel;
    logic [3:0] diff_sel;
  } mst_cfg_t;

  typedef struct packed {
    logic [3:0] chan;
    logic temp;
    logic diff;
  } mst_conv_cmd_t;

endpackage

/* File: verilog/mst_result_mem.sv */
`timescale 1ns/1ns
module mst_result_mem #(
  parameter int DW = 12,
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_r;

  // ----------------------------------------------------------------
  // Storage, no reset so it maps onto plain RAM
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && we && (32'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port; out-of-range reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (ce && re) begin
      rdata_r <= (32'(raddr) < DEPTH) ? mem[raddr] : '0;
    end
  end

  assign rdata = rdata_r;

endmodule // mst_result_mem

/* File: bench/mst_conv_model.sv */
`timescale 1ns/1ns
module mst_conv_model
  import mst_pkg::*;
(
  input wire logic clk,
  input wire logic conv_busy,
  input wire mst_conv_cmd_t conv_cmd,
  output logic [11:0] conv_data
);
  // ------------------------------------------------------------
  // Converter result source
  // ------------------------------------------------------------
  initial conv_data = 12'h000;
  // Steady code tied to the channel in a slot; outside a slot the bus toggles
  // every cycle, so a sample taken at the wrong moment cannot match by chance
  always @(posedge clk) begin
    if (conv_busy) begin
      conv_data <= {conv_cmd.chan, 8'ha5};
    end else begin
      conv_data <= ~conv_data;
    end
  end
endmodule // mst_conv_model

/* File: bench/monitor_scan_timing_sequencer_tb.sv */
`timescale 1ns/1ns
module monitor_scan_timing_sequencer_tb;
  import mst_pkg::*;
  // Short counts keep the run brief; expectations use the same values
  localparam int T = 40;
  localparam int R01 = 30;
  localparam int WS = 25;
  logic sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
  logic conv_start, conv_busy, ref_shdn, busy_q, clr, shdn_wait, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] conv_data;
  mst_conv_cmd_t conv_cmd;
  int fail_count, n_tests, cyc, last_start, period, fall_cnt, first_ch, run_len;
  logic [3:0] run_ch;
  int st_cnt [NUM_CH];
  int slot_len [NUM_CH];
  logic shdn_slot [NUM_CH];
  mst_conv_cmd_t cmd_slot [NUM_CH];

  mst_scan_seq #(.TCONV_CYCLES(T), .REF01_CYCLES(R01), .LONG_WAIT_CYCLES(50),
    .WAIT_STEP_CYCLES(WS)) u_mst_scan_seq (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONV_DATA(conv_data), .CONV_START(conv_start), .CONV_CMD(conv_cmd),
    .CONV_BUSY(conv_busy), .REF_SHDN(ref_shdn));
  mst_conv_model u_mst_conv_model (.clk(sys_clk), .conv_busy(conv_busy),
    .conv_cmd(conv_cmd), .conv_data(conv_data));

  // ------------------------------------------------------------
  // Clock and scan monitor
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Per slot: starts, length, command and shutdown level; scan period from the first slot
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    busy_q <= conv_busy;
    if (clr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        st_cnt[i] <= 0;
        slot_len[i] <= 0;
      end
      fall_cnt <= 0;
      run_len <= 0;
    end else begin
      // A slot's length is filed only once it has ended: next start or busy falling
      if (run_len > 0 && (conv_start || !conv_busy)) slot_len[run_ch] <= run_len;
      if (conv_start) begin
        st_cnt[conv_cmd.chan] <= st_cnt[conv_cmd.chan] + 1;
        run_len <= 1;
        run_ch <= conv_cmd.chan;
        shdn_slot[conv_cmd.chan] <= ref_shdn;
        cmd_slot[conv_cmd.chan] <= conv_cmd;
        if (conv_cmd.chan == first_ch) begin
          period <= cyc - last_start;
          last_start <= cyc;
        end
      end else if (conv_busy) begin
        run_len <= run_len + 1;
      end else begin
        run_len <= 0;
      end
      // Shutdown level is looked at a few cycles into the wait
      if (busy_q && !conv_busy) fall_cnt <= 3;
      else if (fall_cnt > 0) fall_cnt <= fall_cnt - 1;
      if (fall_cnt == 1) shdn_wait <= ref_shdn;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout(input string what);
    fail_count++;
    $display("Error at %0t: timeout on %s", $time, what);
    final_report();
  endtask
  // One APB transfer; an idle edge follows so requests never collide
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) timeout("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic apply_reset();
    rst_n <= 1'b0;
    clr <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    clr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_starts(input int n);
    int k;
    k = 0;
    while (st_cnt[first_ch] < n && k < 40000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 40000) timeout("scan");
  endtask
  // Configure as the host does, start scanning, measure the third scan start
  task automatic run_scan(input logic [1:0] mode, input logic [2:0] wsel,
      input logic [9:0] chen, input logic [11:0] cfg, input int first, input int exp_p);
    apply_reset();
    first_ch = first;
    apb(1'b1, ADDR_CHAN_EN, {22'h0, chen});
    apb(1'b1, ADDR_INPUT_CFG, {20'h0, cfg});
    apb(1'b1, ADDR_SETUP, {24'h0, wsel, 2'b00, mode, 1'b1});
    wait_starts(3);
    chk(period, exp_p);
    apb(1'b0, ADDR_SCAN_PERIOD, 32'h0);
    chk(rd, exp_p);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b1;
    first_ch = 0;
    cyc = 0;
    last_start = 0;
    period = 0;
    fail_count = 0;
    n_tests = 0;
    // Reset values, unmapped and read-only places
    apply_reset();
    chk({30'h0, conv_busy, ref_shdn}, 32'h1);
    apb(1'b0, ADDR_SETUP, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_CHAN_EN, 32'h0);
    chk(rd, 32'h3ff);
    apb(1'b0, ADDR_INPUT_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, ADDR_STATUS, 32'hffffffff);
    chk({31'h0, err}, 32'h0);
    $display("Test reset done");
    // Mode 10: voltage slot, no power-up, then a clock-enable freeze
    run_scan(2'h2, 3'h1, 10'h001, 12'h000, 0, VCONV_CYC + WS);
    chk(slot_len[0], VCONV_CYC);
    chk({31'h0, shdn_wait}, 32'h0);
    wait_starts(4);
    repeat (100) @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (1300) @(posedge sys_clk);
    chk(slot_len[0], VCONV_CYC + 10);
    $display("Test mode 10 done");
    // Mode 11: differential pair, single-ended and internal temperature
    run_scan(2'h3, 3'h0, 10'h324, 12'h22c, 2, 3 * T + VCONV_CYC + 1);
    chk(st_cnt[3], 0);
    chk(st_cnt[0], 0);
    chk(st_cnt[5] + st_cnt[8] + st_cnt[9], 6);
    chk(32'(cmd_slot[2]), 32'h0b);
    chk(32'(cmd_slot[5]), 32'h16);
    chk(slot_len[2], T);
    chk(slot_len[8], T);
    chk(slot_len[9], VCONV_CYC);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h2a5);
    apb(1'b0, 8'h60, 32'h0);
    chk(rd, 32'h8a5);
    $display("Test temperature done");
    // Mode 01 with a long and a short wait
    run_scan(REF_MODE_01, 3'h3, 10'h001, 12'h000, 0, R01 + VCONV_CYC + 3 * WS);
    chk({30'h0, shdn_wait, shdn_slot[0]}, 32'h2);
    run_scan(REF_MODE_01, 3'h2, 10'h001, 12'h000, 0, VCONV_CYC + 2 * WS);
    chk({31'h0, shdn_wait}, 32'h0);
    $display("Test mode 01 done");
    // Mode 00: power-up before the temperature slot only
    run_scan(REF_MODE_00, 3'h1, 10'h005, 12'h004, 0, VCONV_CYC + REF00_CYC + T + WS);
    chk({30'h0, shdn_slot[0], shdn_slot[2]}, 32'h2);
    $display("Test mode 00 done");
    final_report();
  end
endmodule // monitor_scan_timing_sequencer_tb
